/* rtl/shift_parity_unit.sv */
// Shift group and odd parity skip test datapath with timed completion
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module shift_parity_unit
   import shift_parity_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic [1:0] op_sel,
   input wire logic [6:0] major_code,
   input wire logic [MINOR_W-1:0] minor_code,
   input wire logic same_bank,
   input wire logic [WORD_W-1:0] reg_a,
   input wire logic [WORD_W-1:0] reg_a_next,
   input wire logic [WORD_W-1:0] operand,
   input wire logic [17:0] u_field,
   output logic busy,
   output logic done,
   output logic skip_following_instruction,
   output logic write_a,
   output logic write_a_next,
   output logic [WORD_W-1:0] result_a,
   output logic [WORD_W-1:0] result_a_next
);

   typedef enum logic [2:0] {
      IDLE = 3'b001,
      RUN = 3'b010,
      FINISH = 3'b100
   } state_e;

   state_e state;
   state_e next_state;
   logic [CYC_W-1:0] timer;
   logic [CYC_W-1:0] next_timer;
   logic busy_q;
   logic next_busy;
   logic done_q;
   logic next_done;
   logic skip_q;
   logic next_skip;
   logic wa_q;
   logic next_wa;
   logic wan_q;
   logic next_wan;
   logic [WORD_W-1:0] ra_q;
   logic [WORD_W-1:0] next_ra;
   logic [WORD_W-1:0] ran_q;
   logic [WORD_W-1:0] next_ran;

   //////////////////////////////////////////////////////////////////////////////
   // Datapath functions

   function automatic logic [5:0] norm_count(input logic [WORD_W-1:0] w);
      logic [5:0] n;
      logic [WORD_W-1:0] v;
      logic stop;
      n = 6'h0;
      v = w;
      stop = 1'b0;
      // Bounded loop keeps the search combinational and caps it at 35
      for (int i = 0; i < 35; i++) begin
         if (!stop && v[35] == v[34]) begin
            v = {v[34:0], v[35]};
            n = n + 6'h1;
         end else begin
            stop = 1'b1;
         end
      end
      return n;
   endfunction

   function automatic logic [2*WORD_W-1:0] pair_shift(input logic [2*WORD_W-1:0] p, input logic [CNT_W-1:0] c,
                                                       input logic rot, input logic sfill);
      logic [4*WORD_W-1:0] ext;
      logic [4*WORD_W-1:0] sh;
      if (rot)
         ext = {p, p};
      else if (sfill)
         ext = {{(2*WORD_W){p[2*WORD_W-1]}}, p};
      else
         ext = {{(2*WORD_W){1'b0}}, p};
      sh = ext >> c; // Low-end bits fall off the bottom
      return sh[2*WORD_W-1:0];
   endfunction

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] count72;
   logic [WORD_W-1:0] product;
   logic parity_odd;
   logic is_shift;
   logic is_par;
   logic [2*WORD_W-1:0] sh_single_rot;
   logic [2*WORD_W-1:0] sh_single;
   logic [2*WORD_W-1:0] sh_pair;
   logic [5:0] ncount;

   assign count = u_field[CNT_W-1:0];
   // Counts past 72 are undefined for programs; clamp so rotation stays within the doubled pair
   assign count72 = (count > 7'h48) ? 7'h48 : count;
   assign product = reg_a & operand;
   assign parity_odd = ^product;
   assign is_shift = (op_sel == OP_SHIFT) && (major_code == SHIFT_MAJOR);
   assign is_par = (op_sel == OP_ODD_PARITY);
   assign sh_single_rot = pair_shift({reg_a, reg_a}, CNT_W'(count72 % 7'h24), 1'b1, 1'b0);
   assign sh_single = pair_shift({reg_a, {WORD_W{1'b0}}}, count72, 1'b0,
                                 minor_code == single_right_sign_fill_shift);
   assign sh_pair = pair_shift({reg_a, reg_a_next}, count72, minor_code == double_right_rotate,
                               minor_code == double_right_sign_fill_shift);
   assign ncount = norm_count(operand);

   //////////////////////////////////////////////////////////////////////////////
   // Sequencer and result capture

   always_comb begin
      next_state = state;
      next_timer = timer;
      next_busy = busy_q;
      next_done = 1'b0;
      next_skip = skip_q;
      next_wa = wa_q;
      next_wan = wan_q;
      next_ra = ra_q;
      next_ran = ran_q;
      case (state)
         IDLE: begin
            if (start && (is_par || is_shift)) begin
               next_state = RUN;
               next_busy = 1'b1;
               next_skip = 1'b0;
               next_wa = 1'b0;
               next_wan = 1'b0;
               if (is_par) begin
                  next_skip = parity_odd;
                  next_wan = 1'b0;
                  if (same_bank)
                     next_timer = parity_odd ? CYC_PAR_SAME_SKIP : CYC_PAR_SAME_NOSKIP;
                  else
                     next_timer = parity_odd ? CYC_PAR_ALT_SKIP : CYC_PAR_ALT_NOSKIP;
               end else begin
                  next_timer = CYC_SHIFT;
                  next_wa = 1'b1;
                  case (minor_code)
                     single_right_rotate: next_ra = sh_single_rot[WORD_W-1:0];
                     double_right_rotate, double_right_sign_fill_shift: begin
                        next_ra = sh_pair[2*WORD_W-1:WORD_W];
                        next_ran = sh_pair[WORD_W-1:0];
                        next_wan = 1'b1;
                     end
                     single_right_zero_fill_shift, single_right_sign_fill_shift:
                        next_ra = sh_single[2*WORD_W-1:WORD_W];
                     scale_factor_normalize: begin
                        next_ra = (operand << ncount) | (operand >> (6'h24 - ncount));
                        next_ran = {30'h0, ncount};
                        next_wan = 1'b1;
                        next_timer = same_bank ? CYC_NORM_SAME : CYC_NORM_ALT;
                     end
                     default: next_wa = 1'b0;
                  endcase
               end
            end
         end
         RUN: begin
            next_timer = timer - CYC_W'(1);
            if (timer == CYC_W'(2))
               next_state = FINISH;
         end
         FINISH: begin
            next_state = IDLE;
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         default: next_state = IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= IDLE;
         timer <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         skip_q <= 1'b0;
         wa_q <= 1'b0;
         wan_q <= 1'b0;
         ra_q <= WORD_RESET;
         ran_q <= WORD_RESET;
      end else begin
         state <= next_state;
         timer <= next_timer;
         busy_q <= next_busy;
         done_q <= next_done;
         skip_q <= next_skip;
         wa_q <= next_wa;
         wan_q <= next_wan;
         ra_q <= next_ra;
         ran_q <= next_ran;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign skip_following_instruction = skip_q;
   assign write_a = wa_q;
   assign write_a_next = wan_q;
   assign result_a = ra_q;
   assign result_a_next = ran_q;

   //////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [CYC_W-1:0] run_len;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         run_len <= '0;
      else if (!busy_q)
         run_len <= '0;
      else
         run_len <= run_len + CYC_W'(1);
   end

   // Remembers the kind of the running operation, so the done check knows how long it should have taken
   logic fixed_shift_run;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         fixed_shift_run <= 1'b0;
      else if (start && !busy_q)
         fixed_shift_run <= is_shift && minor_code != scale_factor_normalize && minor_code != 3'h5 &&
                            minor_code != 3'h7;
   end

   sequence s_shift_start;
      start && !busy_q && is_shift && minor_code != scale_factor_normalize && minor_code != 3'h5 && minor_code != 3'h7;
   endsequence

   chk_shift_fixed_time: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_shift_start |=> busy_q [*8])
      else $error("shift dropped busy too early");

   chk_shift_done_count: assert property (@(posedge ref_clk) disable iff (!resetn)
      done_q && fixed_shift_run |-> run_len == CYC_SHIFT)
      else $error("shift did not finish in 4.0 us");

   chk_parity_skip_value: assert property (@(posedge ref_clk) disable iff (!resetn)
      start && !busy_q && is_par |=> skip_following_instruction == $past(parity_odd))
      else $error("parity skip decision wrong");

   chk_parity_no_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      busy_q && !write_a |-> !write_a_next)
      else $error("parity test wrote next register");

   chk_parity_write_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
      start && !busy_q && is_par |=> !write_a && !write_a_next)
      else $error("parity test raised a write flag");

   chk_parity_skip_time: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(done_q) && skip_q && !wa_q |-> run_len == CYC_PAR_ALT_SKIP || run_len == CYC_PAR_SAME_SKIP)
      else $error("parity skip timing wrong");

   chk_norm_top_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(busy_q) && $past(is_shift) && $past(minor_code) == scale_factor_normalize && result_a_next < 36'h23
         |-> result_a[35] != result_a[34])
      else $error("normalized value top bits equal");

   chk_norm_count_cap: assert property (@(posedge ref_clk) disable iff (!resetn)
      start && !busy_q && is_shift && minor_code == scale_factor_normalize |=> result_a_next <= 36'h23)
      else $error("normalize count out of range");

   chk_norm_zero_count: assert property (@(posedge ref_clk) disable iff (!resetn)
      start && !busy_q && is_shift && minor_code == scale_factor_normalize && operand[35] != operand[34]
         |=> result_a_next == 36'h0 && result_a == $past(operand))
      else $error("already scaled operand rotated");

   chk_norm_flat_word: assert property (@(posedge ref_clk) disable iff (!resetn)
      start && !busy_q && is_shift && minor_code == scale_factor_normalize && (&operand || ~|operand)
         |=> result_a_next == 36'h23)
      else $error("flat operand count not 35");

   chk_zero_fill: assert property (@(posedge ref_clk) disable iff (!resetn)
      start && !busy_q && is_shift && minor_code == single_right_zero_fill_shift
         |=> result_a == ($past(reg_a) >> $past(count72)))
      else $error("zero fill shift wrong");

endmodule

/* include/shift_parity_pkg.sv */
// Constants, codes and timing for the shift and parity test unit
package shift_parity_pkg;
   localparam int WORD_W = 36;
   localparam int CNT_W = 7;
   localparam int MINOR_W = 3;
   localparam int CLK_PERIOD_NS = 10;
   // Operation group selects from instruction control
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_ODD_PARITY = 2'h1;
   localparam logic [1:0] OP_SHIFT = 2'h2;
   // Shift group major code and minor codes
   localparam logic [6:0] SHIFT_MAJOR = 7'h3b;
   localparam logic [2:0] single_right_rotate = 3'h0;
   localparam logic [2:0] double_right_rotate = 3'h1;
   localparam logic [2:0] single_right_zero_fill_shift = 3'h2;
   localparam logic [2:0] single_right_sign_fill_shift = 3'h3;
   localparam logic [2:0] double_right_sign_fill_shift = 3'h4;
   localparam logic [2:0] scale_factor_normalize = 3'h6;
   localparam logic [5:0] NORM_MAX_ROT = 6'h23;
   // Execution times in nanoseconds
   localparam int T_PAR_ALT_NOSKIP_NS = 10000;
   localparam int T_PAR_ALT_SKIP_NS = 6000;
   localparam int T_PAR_SAME_NOSKIP_NS = 14000;
   localparam int T_PAR_SAME_SKIP_NS = 10000;
   localparam int T_SHIFT_NS = 4000;
   localparam int T_NORM_ALT_NS = 6000;
   localparam int T_NORM_SAME_NS = 10000;
   localparam int CYC_W = 11;
   localparam logic [CYC_W-1:0] CYC_PAR_ALT_NOSKIP = CYC_W'(T_PAR_ALT_NOSKIP_NS / CLK_PERIOD_NS);
   localparam logic [CYC_W-1:0] CYC_PAR_ALT_SKIP = CYC_W'(T_PAR_ALT_SKIP_NS / CLK_PERIOD_NS);
   localparam logic [CYC_W-1:0] CYC_PAR_SAME_NOSKIP = CYC_W'(T_PAR_SAME_NOSKIP_NS / CLK_PERIOD_NS);
   localparam logic [CYC_W-1:0] CYC_PAR_SAME_SKIP = CYC_W'(T_PAR_SAME_SKIP_NS / CLK_PERIOD_NS);
   localparam logic [CYC_W-1:0] CYC_SHIFT = CYC_W'(T_SHIFT_NS / CLK_PERIOD_NS);
   localparam logic [CYC_W-1:0] CYC_NORM_ALT = CYC_W'(T_NORM_ALT_NS / CLK_PERIOD_NS);
   localparam logic [CYC_W-1:0] CYC_NORM_SAME = CYC_W'(T_NORM_SAME_NS / CLK_PERIOD_NS);
   localparam logic [WORD_W-1:0] WORD_RESET = 36'h0;
endpackage

/* verification/instr_seq_model.sv */
// Instruction control stand-in: presents one operation and times its answer
`timescale 1ns/10ps
module instr_seq_model
   import shift_parity_pkg::*;
(
   input wire logic ref_clk,
   input wire logic done,
   output logic start,
   output logic [1:0] op_sel,
   output logic [6:0] major_code,
   output logic [MINOR_W-1:0] minor_code,
   output logic same_bank,
   output logic [WORD_W-1:0] reg_a,
   output logic [WORD_W-1:0] reg_a_next,
   output logic [WORD_W-1:0] operand,
   output logic [17:0] u_field
);
   initial begin
      start = 1'b0;
      op_sel = OP_NONE;
      major_code = SHIFT_MAJOR;
      minor_code = 3'h0;
      same_bank = 1'b0;
      reg_a = WORD_RESET;
      reg_a_next = WORD_RESET;
      operand = WORD_RESET;
      u_field = 18'h0;
   end

   // Operands stay put until the answer, as the sequencer holds its registers.
   // Returns the edges from the take edge to done, or -1 when done never came.
   task automatic send(input logic [1:0] op, input logic [2:0] mc, input logic sb,
         input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] an,
         input logic [WORD_W-1:0] u_opd, input logic [17:0] u, output int cyc);
      @(negedge ref_clk);
      op_sel = op;
      minor_code = mc;
      same_bank = sb;
      reg_a = a;
      reg_a_next = an;
      operand = u_opd;
      u_field = u;
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      cyc = 0;
      while (done !== 1'b1 && cyc < 2000) begin
         @(negedge ref_clk);
         cyc++;
      end
      if (done !== 1'b1) cyc = -1;
   endtask

   // Lets a scenario present a foreign major code; the unit must then ignore a shift select, while a parity select still runs
   task automatic set_major(input logic [6:0] mj);
      @(negedge ref_clk);
      major_code = mj;
   endtask
endmodule

/* verification/shift_and_parity_test_unit_tb_top.sv */
// Self-checking bench for the shift and parity test unit
`timescale 1ns/10ps
module shift_and_parity_test_unit_tb_top
   import shift_parity_pkg::*;
   ;
   logic ref_clk = 1'b0;
   logic resetn;
   logic start, same_bank, busy, done, skip_following_instruction, write_a, write_a_next;
   logic [1:0] op_sel;
   logic [6:0] major_code;
   logic [MINOR_W-1:0] minor_code;
   logic [WORD_W-1:0] reg_a, reg_a_next, operand, result_a, result_a_next;
   logic [17:0] u_field;
   int errors = 0;
   int checks_done = 0;
   int cyc;

   always #5 ref_clk = ~ref_clk;

   shift_parity_unit DUT (.ref_clk(ref_clk), .resetn(resetn), .start(start), .op_sel(op_sel),
      .major_code(major_code), .minor_code(minor_code), .same_bank(same_bank), .reg_a(reg_a),
      .reg_a_next(reg_a_next), .operand(operand), .u_field(u_field), .busy(busy), .done(done),
      .skip_following_instruction(skip_following_instruction), .write_a(write_a),
      .write_a_next(write_a_next), .result_a(result_a), .result_a_next(result_a_next));

   instr_seq_model u_seq (.ref_clk(ref_clk), .done(done), .start(start), .op_sel(op_sel),
      .major_code(major_code), .minor_code(minor_code), .same_bank(same_bank), .reg_a(reg_a),
      .reg_a_next(reg_a_next), .operand(operand), .u_field(u_field));

   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic run(input logic [1:0] op, input logic [2:0] mc, input logic sb, input logic [35:0] a,
         input logic [35:0] an, input logic [35:0] u_opd, input logic [17:0] u);
      u_seq.send(op, mc, sb, a, an, u_opd, u, cyc);
      if (cyc < 0) begin
         errors++;
         $display("ERROR t=%0t no completion", $time);
         test_done;
      end
   endtask

   // Pair results are {first, next-higher}; unwritten halves keep the input
   function automatic logic [71:0] exp_shift(input logic [2:0] mc, input logic [35:0] a,
         input logic [35:0] an, input int n);
      logic [71:0] p;
      logic [71:0] r;
      p = {a, an};
      r = p;
      case (mc)
         3'h0: r[71:36] = 36'({a, a} >> (n % 36));
         3'h1: r = 72'({p, p} >> (n % 72));
         3'h2: r[71:36] = a >> n;
         3'h3: r[71:36] = 36'($signed(a) >>> n);
         3'h4: r = 72'($signed(p) >>> n);
         default: r = p;
      endcase
      return r;
   endfunction

   function automatic logic [71:0] exp_norm(input logic [35:0] u);
      logic [35:0] v;
      int k;
      v = u;
      k = 0;
      while (v[35] == v[34] && k < 35) begin
         v = {v[34:0], v[35]};
         k++;
      end
      return {v, 36'(k)};
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // High u bits are set on purpose; count 72 is the largest a program may use
   task automatic t_shifts;
      logic [35:0] av [2] = '{36'h80f0f1234, 36'h3c5a5a001};
      int ns [2] = '{13, 72};
      logic [71:0] e;
      for (int m = 0; m < 6; m++) begin
         for (int i = 0; i < 4; i++) begin
            run(OP_SHIFT, 3'(m), i[0], av[i[1]], 36'h123456789, 36'h0, 18'h3ff80 | 18'(ns[i[0]]));
            e = exp_shift(3'(m), av[i[1]], 36'h123456789, ns[i[0]]);
            chk(72'(cyc), 72'(CYC_SHIFT));
            chk(72'(write_a), 72'(m < 5));
            chk(72'(write_a_next), 72'(m == 1 || m == 4));
            if (m < 5) chk(72'(result_a), 72'(e[71:36]));
            if (m == 1 || m == 4) chk(72'(result_a_next), 72'(e[35:0]));
         end
      end
   endtask

   // An unscaled word, already scaled, all zeros, all ones and a wrap case
   task automatic t_norm;
      logic [35:0] uv [5] = '{36'h000036924, 36'h400000000, 36'h0, 36'hfffffffff, 36'hc00000001};
      for (int i = 0; i < 5; i++) begin
         run(OP_SHIFT, scale_factor_normalize, i[0], 36'h555555555, 36'h0, uv[i], 18'h0);
         chk(72'(cyc), 72'(i[0] ? CYC_NORM_SAME : CYC_NORM_ALT));
         chk({result_a, result_a_next}, exp_norm(uv[i]));
         chk(72'({write_a, write_a_next}), 72'h3);
      end
   endtask

   task automatic t_parity;
      logic [35:0] u;
      logic s;
      logic [10:0] t;
      for (int i = 0; i < 4; i++) begin
         u = i[0] ? 36'h00000001f : 36'hfffffffff;
         s = ^(36'h0f0f0f0f0 & u);
         t = i[1] ? (s ? CYC_PAR_SAME_SKIP : CYC_PAR_SAME_NOSKIP) : (s ? CYC_PAR_ALT_SKIP : CYC_PAR_ALT_NOSKIP);
         run(OP_ODD_PARITY, 3'h0, i[1], 36'h0f0f0f0f0, 36'h0, u, 18'h0);
         chk(72'(skip_following_instruction), 72'(s));
         chk(72'({write_a, write_a_next}), 72'h0);
         chk(72'(cyc), 72'(t));
      end
   endtask

   // A foreign major code and the empty select are ignored and leave the results alone
   task automatic t_reject;
      u_seq.set_major(7'h3a);
      u_seq.send(OP_SHIFT, single_right_rotate, 1'b0, 36'h1, 36'h0, 36'h0, 18'h1, cyc);
      chk(72'(cyc < 0), 72'h1);
      chk(72'(busy), 72'h0);
      u_seq.set_major(SHIFT_MAJOR);
      u_seq.send(OP_NONE, single_right_rotate, 1'b0, 36'h1, 36'h0, 36'h0, 18'h1, cyc);
      chk(72'(cyc < 0), 72'h1);
      chk({result_a, result_a_next}, exp_norm(36'hc00000001));
   endtask

   initial begin
      resetn = 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      chk(72'({busy, done}), 72'h0);
      t_parity;
      t_shifts;
      t_norm;
      t_reject;
      test_done;
   end
endmodule
